/* File: pkg/fecr_pkg.sv */
/*
  Constants and types of the front-end control register block that
  holds the three upper control words (selects 1101, 1110, 1111).
  Assumes one core clock at 25 MHz and an active-low async reset that
  stands for the internal power-on reset.
*/
// Overview of operation
// [RQ1] select 1101 loads rf-only and C/D offsets
// [RQ2] select 1110 loads RF filter settings
// [RQ3] select 1111 loads phase-detect filter settings
// [RQ4] rf-only tri-states focus and radial servo outputs
// [RQ5] RF data path stays active in rf-only
// [RQ6] bits 7..4: C offset, 20/60 mV
// [RQ7] bits 3..0: D offset, same ranges
// [RQ8] bit 9 enables RF noise filter
// [RQ9] bit 8 enables RF equalizer
// [RQ10] bit 7 selects low/high boost
// [RQ11] bits 6..0 corner, 12 to 145 MHz
// [RQ12] bits 5..3 lead/lag start frequency table
// [RQ13] bits 2..0 low-pass corner table
// [RQ14] all settings serially programmable, pins may modify
// [RQ15] power-on reset clears power-on bit: standby
// [RQ16] standby switches off circuits and lasers
// [RQ17] cd laser on = enabled and powered
// [RQ18] dvd laser on = enabled and powered
// [RQ19] offset scale bit picks normal/triple range
// [RQ20] only selected word updates, unused bits ignored
// [RQ21] undocumented phase codes are reserved
package fecr_pkg;
  // serial control word
  localparam int unsigned WORD_W = 16;
  localparam int unsigned SEL_HI = 15;
  localparam int unsigned SEL_LO = 12;
  localparam int unsigned CNT_W = 5;
  localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
  // register selects
  localparam logic [3:0] SEL_CD = 4'hD;
  localparam logic [3:0] SEL_RF = 4'hE;
  localparam logic [3:0] SEL_PD = 4'hF;
  // field positions, select 1101
  localparam int unsigned RF_ONLY_MODE_BIT = 11;
  localparam int unsigned OFFC_HI = 7;
  localparam int unsigned OFFC_LO = 4;
  localparam int unsigned OFFD_HI = 3;
  localparam int unsigned OFFD_LO = 0;
  // field positions, select 1110
  localparam int unsigned NF_BIT = 9;
  localparam int unsigned EQ_BIT = 8;
  localparam int unsigned BOOST_BIT = 7;
  localparam int unsigned CORNER_HI = 6;
  localparam int unsigned CORNER_LO = 0;
  // field positions, select 1111
  localparam int unsigned LL_HI = 5;
  localparam int unsigned LL_LO = 3;
  localparam int unsigned LP_HI = 2;
  localparam int unsigned LP_LO = 0;

  typedef struct packed {
    logic rf_only_mode;
    logic [3:0] central_offset_c_code;
    logic [3:0] central_offset_d_code;
  } fecr_cd_t;

  typedef struct packed {
    logic rf_noise_filter_en;
    logic rf_equalizer_en;
    logic rf_boost_sel;
    logic [6:0] rf_corner_code;
  } fecr_rf_t;

  typedef struct packed {
    logic [2:0] phase_leadlag_code;
    logic [2:0] phase_lowpass_code;
  } fecr_pd_t;

  // reset values: everything off, lowest codes
  localparam fecr_cd_t CD_RST = 9'h000;
  localparam fecr_rf_t RF_RST = 10'h000;
  localparam fecr_pd_t PD_RST = 6'h00;
  localparam logic PWR_RST = 1'b0;

  // corner frequency span in MHz
  localparam logic [15:0] CORNER_MIN_MHZ = 16'h000C;
  localparam logic [15:0] CORNER_MAX_MHZ = 16'h0091;
  localparam logic [15:0] CORNER_CODE_MAX = 16'h007F;
  // central offset full scale in mV
  localparam logic [9:0] OFFS_FS_NORM_MV = 10'h014;
  localparam logic [9:0] OFFS_FS_TRIPLE_MV = 10'h03C;
  localparam logic [9:0] OFFS_CODE_MAX = 10'h00F;
  // lead/lag start frequencies in MHz
  localparam logic [7:0] LL_F0_MHZ = 8'h01;
  localparam logic [7:0] LL_F1_MHZ = 8'h05;
  localparam logic [7:0] LL_F2_MHZ = 8'h0A;
  localparam logic [7:0] LL_F3_MHZ = 8'h12;
  localparam logic [7:0] LL_F4_MHZ = 8'h18;
  // low-pass corners in MHz
  localparam logic [7:0] LP_F0_MHZ = 8'h0A;
  localparam logic [7:0] LP_F1_MHZ = 8'h32;
  localparam logic [7:0] LP_F2_MHZ = 8'h64;
  localparam logic [7:0] LP_F3_MHZ = 8'hB4;
  localparam logic [7:0] LP_F7_MHZ = 8'hF0;
  // reserved codes read back as 0 MHz
  localparam logic [7:0] FREQ_RSVD = 8'h00;
endpackage

/* File: src/fecr_serial_rx.sv */
/*
  Serial word receiver: shifts data MSB first on rising serial clock
  while enable is high, hands the word over when enable falls.
  Assumes already synchronised inputs on core_clk_i.
*/
module fecr_serial_rx
  import fecr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic sdata_i,
  input wire logic sen_i,
  output logic word_vld_o,
  output logic [WORD_W-1:0] word_o
);
  logic sclk_q; // previous clock level
  logic sclk_d;
  logic sen_q; // previous enable level
  logic sen_d;
  logic [WORD_W-1:0] shift_q;
  logic [WORD_W-1:0] shift_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic vld_d;
  logic [WORD_W-1:0] word_d;

  // shift and frame; wrong bit counts are dropped whole
  always_comb begin
    sclk_d = sclk_i;
    sen_d = sen_i;
    shift_d = shift_q;
    cnt_d = cnt_q;
    vld_d = 1'b0;
    word_d = word_o;
    if (sen_i && !sen_q) begin
      cnt_d = '0; // frame start
    end else if (sen_i && sclk_i && !sclk_q) begin
      shift_d = {shift_q[WORD_W-2:0], sdata_i};
      // saturate past a full word so overlong frames fail
      if (cnt_q <= BITS_PER_WORD) begin
        cnt_d = cnt_q + 5'h01;
      end
    end else if (!sen_i && sen_q) begin
      if (cnt_q == BITS_PER_WORD) begin
        vld_d = 1'b1;
        word_d = shift_q;
      end
    end
  end

  // state registers
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b0;
      sen_q <= 1'b0;
      shift_q <= '0;
      cnt_q <= '0;
      word_vld_o <= 1'b0;
      word_o <= '0;
    end else begin
      sclk_q <= sclk_d;
      sen_q <= sen_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      word_vld_o <= vld_d;
      word_o <= word_d;
    end
  end
endmodule

/* File: src/fecr_sync3.sv */
/*
  Three-flop pin synchroniser with agreement filter.
  Assumes the pin is asynchronous to core_clk_i.
*/
module fecr_sync3
  import fecr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q; // metastable stage, read only by s2
  logic s2_q;
  logic s3_q;
  logic level_d;

  // accept a change only once stages 2 and 3 agree
  always_comb begin
    level_d = level_o;
    if (s2_q == s3_q) begin
      level_d = s3_q;
    end
  end

  // plain shift chain
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_o <= level_d;
    end
  end
endmodule

/* File: src/fecr_top.sv */
/*
  Upper control words of the front end: rf-only and central C/D
  offsets, RF filter settings, phase-detect filter settings, plus
  standby and laser-on indications. Words arrive over the serial
  control pins. Assumes power and laser-enable bits of the lower
  words come in on core_clk_i from the neighbouring register logic.
*/
module fecr_top
  import fecr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_en_i,
  input wire logic rf_only_pin_i,
  input wire logic servo_offset_scale_i,
  input wire logic power_on_wr_i,
  input wire logic power_on_wdata_i,
  input wire logic cd_laser_en_i,
  input wire logic dvd_laser_en_i,
  output fecr_cd_t cd_cfg_o,
  output fecr_rf_t rf_cfg_o,
  output fecr_pd_t pd_cfg_o,
  output logic [3:0] focus_servo_out_oe_o,
  output logic [1:0] radial_servo_out_oe_o,
  output logic rf_path_en_o,
  output logic standby_o,
  output logic cd_laser_supply_en_o,
  output logic dvd_laser_supply_en_o,
  output logic cd_laser_on_o,
  output logic dvd_laser_on_o,
  output logic offset_triple_o,
  output logic [5:0] offset_c_mv_o,
  output logic [5:0] offset_d_mv_o,
  output logic [7:0] rf_corner_mhz_o,
  output logic [7:0] leadlag_mhz_o,
  output logic [7:0] lowpass_mhz_o,
  output logic phase_code_rsvd_o
);
  // synchronised pin levels
  logic [3:0] pin_raw;
  logic [3:0] pin_lvl;
  // received words
  logic word_vld;
  logic [WORD_W-1:0] word;
  // control word registers
  fecr_cd_t cd_q;
  fecr_cd_t cd_d;
  fecr_rf_t rf_q;
  fecr_rf_t rf_d;
  fecr_pd_t pd_q;
  fecr_pd_t pd_d;
  logic pwr_q; // power_on_ctrl
  logic pwr_d;
  // effective modes
  logic rf_only_eff;
  logic [9:0] offs_fs;
  // output group next values
  logic [3:0] f_oe_d;
  logic [1:0] r_oe_d;
  logic rf_en_d;
  logic stby_d;
  logic cd_sup_d;
  logic dvd_sup_d;
  logic cd_on_d;
  logic dvd_on_d;
  logic trip_d;
  logic [5:0] offc_d;
  logic [5:0] offd_d;
  logic [7:0] corner_d;
  logic [7:0] ll_d;
  logic [7:0] lp_d;
  logic rsvd_d;

  // select field match, shared by all three words
  function automatic logic sel_hit(input logic [WORD_W-1:0] w,
                                   input logic [3:0] sel);
    sel_hit = (w[SEL_HI:SEL_LO] == sel);
  endfunction

  // lead/lag code to MHz, reserved codes give zero
  function automatic logic [7:0] ll_mhz(input logic [2:0] c);
    case (c)
      3'h0: ll_mhz = LL_F0_MHZ;
      3'h1: ll_mhz = LL_F1_MHZ;
      3'h2: ll_mhz = LL_F2_MHZ;
      3'h3: ll_mhz = LL_F3_MHZ;
      3'h4: ll_mhz = LL_F4_MHZ;
      default: ll_mhz = FREQ_RSVD; // RQ21
    endcase
  endfunction

  // low-pass code to MHz, reserved codes give zero
  function automatic logic [7:0] lp_mhz(input logic [2:0] c);
    case (c)
      3'h0: lp_mhz = LP_F0_MHZ;
      3'h1: lp_mhz = LP_F1_MHZ;
      3'h2: lp_mhz = LP_F2_MHZ;
      3'h3: lp_mhz = LP_F3_MHZ;
      3'h7: lp_mhz = LP_F7_MHZ;
      default: lp_mhz = FREQ_RSVD; // RQ21
    endcase
  endfunction

  // offset code scaled to mV over the chosen full scale
  function automatic logic [5:0] offs_mv(input logic [3:0] c,
                                         input logic [9:0] fs);
    logic [9:0] p;
    p = ({6'h00, c} * fs) / OFFS_CODE_MAX;
    offs_mv = p[5:0];
  endfunction

  // corner code mapped linearly onto 12..145 MHz
  function automatic logic [7:0] corner_mhz(input logic [6:0] c);
    logic [15:0] p;
    p = CORNER_MIN_MHZ + ({9'h000, c} *
        (CORNER_MAX_MHZ - CORNER_MIN_MHZ)) / CORNER_CODE_MAX;
    corner_mhz = p[7:0];
  endfunction

  assign pin_raw = {rf_only_pin_i, ser_en_i, ser_data_i, ser_clk_i};

  // every pin gets its own three-flop synchroniser
  for (genvar i = 0; i < 4; i++) begin : g_sync
    fecr_sync3 u_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(pin_raw[i]),
      .level_o(pin_lvl[i])
    );
  end

  // serial word capture
  fecr_serial_rx u_rx (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .sclk_i(pin_lvl[0]),
    .sdata_i(pin_lvl[1]),
    .sen_i(pin_lvl[2]),
    .word_vld_o(word_vld),
    .word_o(word)
  );

  // word decode: only the addressed register moves
  always_comb begin
    cd_d = cd_q;
    rf_d = rf_q;
    pd_d = pd_q;
    pwr_d = pwr_q;
    if (word_vld) begin
      if (sel_hit(word, SEL_CD)) begin // RQ1 RQ20
        cd_d.rf_only_mode = word[RF_ONLY_MODE_BIT]; // RQ4
        cd_d.central_offset_c_code = word[OFFC_HI:OFFC_LO]; // RQ6
        cd_d.central_offset_d_code = word[OFFD_HI:OFFD_LO]; // RQ7
      end else if (sel_hit(word, SEL_RF)) begin // RQ2 RQ20
        rf_d.rf_noise_filter_en = word[NF_BIT]; // RQ8
        rf_d.rf_equalizer_en = word[EQ_BIT]; // RQ9
        rf_d.rf_boost_sel = word[BOOST_BIT]; // RQ10
        rf_d.rf_corner_code = word[CORNER_HI:CORNER_LO]; // RQ11
      end else if (sel_hit(word, SEL_PD)) begin // RQ3 RQ20
        pd_d.phase_leadlag_code = word[LL_HI:LL_LO]; // RQ12
        pd_d.phase_lowpass_code = word[LP_HI:LP_LO]; // RQ13
      end
    end
    // power bit comes from a lower word over the same serial bus
    if (power_on_wr_i) begin
      pwr_d = power_on_wdata_i; // RQ14
    end
  end

  // register state; reset stands for the power-on reset
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cd_q <= CD_RST;
      rf_q <= RF_RST;
      pd_q <= PD_RST;
      pwr_q <= PWR_RST; // RQ15
    end else begin
      cd_q <= cd_d;
      rf_q <= rf_d;
      pd_q <= pd_d;
      pwr_q <= pwr_d;
    end
  end

  // an external pin can force rf-only on top of the bit
  assign rf_only_eff = cd_q.rf_only_mode | pin_lvl[3]; // RQ14

  // scale bit of another word picks the offset range
  assign offs_fs = servo_offset_scale_i ? OFFS_FS_TRIPLE_MV
                                        : OFFS_FS_NORM_MV; // RQ19

  // derived outputs; servo drivers also stay off in standby
  always_comb begin
    f_oe_d = {4{pwr_q & ~rf_only_eff}}; // RQ4 RQ16
    r_oe_d = {2{pwr_q & ~rf_only_eff}}; // RQ4 RQ16
    rf_en_d = pwr_q; // RQ5
    stby_d = ~pwr_q; // RQ16
    cd_sup_d = pwr_q & cd_laser_en_i; // RQ16
    dvd_sup_d = pwr_q & dvd_laser_en_i; // RQ16
    cd_on_d = cd_laser_en_i & pwr_q; // RQ17
    dvd_on_d = dvd_laser_en_i & pwr_q; // RQ18
    trip_d = servo_offset_scale_i; // RQ19
    offc_d = offs_mv(cd_q.central_offset_c_code, offs_fs); // RQ6
    offd_d = offs_mv(cd_q.central_offset_d_code, offs_fs); // RQ7
    corner_d = corner_mhz(rf_q.rf_corner_code); // RQ11
    ll_d = ll_mhz(pd_q.phase_leadlag_code); // RQ12
    lp_d = lp_mhz(pd_q.phase_lowpass_code); // RQ13
    rsvd_d = (ll_d == FREQ_RSVD) | (lp_d == FREQ_RSVD); // RQ21
  end

  // all outputs leave from flops, one cycle after their cause
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cd_cfg_o <= CD_RST;
      rf_cfg_o <= RF_RST;
      pd_cfg_o <= PD_RST;
      focus_servo_out_oe_o <= 4'h0;
      radial_servo_out_oe_o <= 2'h0;
      rf_path_en_o <= 1'b0;
      standby_o <= 1'b1;
      cd_laser_supply_en_o <= 1'b0;
      dvd_laser_supply_en_o <= 1'b0;
      cd_laser_on_o <= 1'b0;
      dvd_laser_on_o <= 1'b0;
      offset_triple_o <= 1'b0;
      offset_c_mv_o <= 6'h00;
      offset_d_mv_o <= 6'h00;
      rf_corner_mhz_o <= 8'h00;
      leadlag_mhz_o <= 8'h00;
      lowpass_mhz_o <= 8'h00;
      phase_code_rsvd_o <= 1'b0;
    end else begin
      cd_cfg_o <= cd_q;
      rf_cfg_o <= rf_q;
      pd_cfg_o <= pd_q;
      focus_servo_out_oe_o <= f_oe_d;
      radial_servo_out_oe_o <= r_oe_d;
      rf_path_en_o <= rf_en_d;
      standby_o <= stby_d;
      cd_laser_supply_en_o <= cd_sup_d;
      dvd_laser_supply_en_o <= dvd_sup_d;
      cd_laser_on_o <= cd_on_d;
      dvd_laser_on_o <= dvd_on_d;
      offset_triple_o <= trip_d;
      offset_c_mv_o <= offc_d;
      offset_d_mv_o <= offd_d;
      rf_corner_mhz_o <= corner_d;
      leadlag_mhz_o <= ll_d;
      lowpass_mhz_o <= lp_d;
      phase_code_rsvd_o <= rsvd_d;
    end
  end
endmodule

/* File: test/fecr_host.sv */
/*
  Serial bus host model that writes control words, msb first.
  Assumes the bench calls send at a falling core clock edge.
*/
module fecr_host (
  input wire logic core_clk_i,
  output logic ser_clk_o,
  output logic ser_data_o,
  output logic ser_en_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // serial clock stands low outside frames
  initial begin
    ser_clk_o = 1'b0;
    ser_data_o = 1'b0;
    ser_en_o = 1'b0;
  end

  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // nbits from the top of w; half sets the pace, fast or slow
  task automatic send(input logic [15:0] w, input int nbits,
    input int half);
    wait_n(1);
    ser_en_o = 1'b1;
    for (int i = 15; i > 15 - nbits; i--) begin
      ser_data_o = w[i];
      wait_n(half);
      ser_clk_o = 1'b1;
      wait_n(half);
      ser_clk_o = 1'b0;
    end
    wait_n(half);
    ser_en_o = 1'b0;
    // released line shows no stale bit
    ser_data_o = ~ser_data_o;
    wait_n(half);
  endtask
endmodule

/* File: test/fecr_props.sv */
/*
  Checker for the upper control word block, watching only fecr_top's
  ports. Assumes it is bound into fecr_top with one core clock domain.
*/
module fecr_props
  import fecr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic ser_clk_i,
  input wire logic ser_data_i,
  input wire logic ser_en_i,
  input wire logic rf_only_pin_i,
  input wire logic servo_offset_scale_i,
  input wire logic power_on_wr_i,
  input wire logic power_on_wdata_i,
  input wire logic cd_laser_en_i,
  input wire logic dvd_laser_en_i,
  input wire fecr_cd_t cd_cfg_o,
  input wire fecr_rf_t rf_cfg_o,
  input wire fecr_pd_t pd_cfg_o,
  input wire logic [3:0] focus_servo_out_oe_o,
  input wire logic [1:0] radial_servo_out_oe_o,
  input wire logic rf_path_en_o,
  input wire logic standby_o,
  input wire logic cd_laser_supply_en_o,
  input wire logic dvd_laser_supply_en_o,
  input wire logic cd_laser_on_o,
  input wire logic dvd_laser_on_o,
  input wire logic offset_triple_o,
  input wire logic [5:0] offset_c_mv_o,
  input wire logic [5:0] offset_d_mv_o,
  input wire logic [7:0] rf_corner_mhz_o,
  input wire logic [7:0] leadlag_mhz_o,
  input wire logic [7:0] lowpass_mhz_o,
  input wire logic phase_code_rsvd_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  logic [4:0] since_fall_q; // cycles since frame enable fell
  logic [4:0] since_fall_d;
  logic en_q; // enable pin one cycle ago

  // restart on a frame end, saturate so it never wraps
  always_comb begin
    since_fall_d = since_fall_q;
    if (en_q && !ser_en_i) begin
      since_fall_d = 5'h00;
    end else if (since_fall_q != 5'h1F) begin
      since_fall_d = since_fall_q + 5'h01;
    end
  end

  // register the counter and the enable history
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_fall_q <= 5'h1F;
      en_q <= 1'b0;
    end else begin
      since_fall_q <= since_fall_d;
      en_q <= ser_en_i;
    end
  end

  a_oe_rf_only: assert property (
    cd_cfg_o.rf_only_mode |-> focus_servo_out_oe_o == 4'h0 &&
      radial_servo_out_oe_o == 2'h0)
    else $error("servo outputs driven in rf-only mode");
  a_standby_off: assert property (
    standby_o |-> {focus_servo_out_oe_o, radial_servo_out_oe_o,
      cd_laser_supply_en_o, dvd_laser_supply_en_o} == 8'h00)
    else $error("circuit left on in standby");
  a_rf_path_kept: assert property (
    cd_cfg_o.rf_only_mode && !standby_o |-> rf_path_en_o)
    else $error("rf path off in rf-only mode");
  a_laser_on_ind: assert property (
    cd_laser_on_o == ($past(cd_laser_en_i) && !standby_o) &&
      dvd_laser_on_o == ($past(dvd_laser_en_i) && !standby_o))
    else $error("laser-on indication wrong");
  a_reset_standby: assert property (
    !$past(rst_n_i) |-> standby_o && cd_cfg_o == CD_RST &&
      rf_cfg_o == RF_RST && pd_cfg_o == PD_RST)
    else $error("not in standby after reset");
  a_offset_mv: assert property (
    $stable(cd_cfg_o) && cd_cfg_o == $past(cd_cfg_o, 2) &&
      $stable(offset_triple_o) && offset_triple_o ==
      $past(offset_triple_o, 2) |-> offset_c_mv_o ==
      6'(cd_cfg_o.central_offset_c_code * (offset_triple_o ? 60 : 20)
      / 15) && offset_d_mv_o == 6'(cd_cfg_o.central_offset_d_code *
      (offset_triple_o ? 60 : 20) / 15))
    else $error("central offset value wrong");
  a_corner_map: assert property (
    $past(rst_n_i) && $stable(rf_cfg_o) && rf_cfg_o ==
      $past(rf_cfg_o, 2) |-> rf_corner_mhz_o ==
      8'(12 + rf_cfg_o.rf_corner_code * 133 / 127))
    else $error("corner frequency wrong");
  a_cfg_window: assert property (
    !$stable(cd_cfg_o) || !$stable(rf_cfg_o) || !$stable(pd_cfg_o)
      |-> since_fall_q <= 5'h0C)
    else $error("setting changed without a word");

  c_rf_only: cover property (cd_cfg_o.rf_only_mode && !standby_o);
  c_rsvd: cover property (phase_code_rsvd_o);
  c_wake: cover property ($fell(standby_o));
endmodule

/* File: test/fecr_top_tb.sv */
/*
  Self-checking bench for fecr_top: the host model writes words, the
  bench drives power, laser enables, scale and the rf-only pin.
  Assumes fecr_pkg, fecr_top, fecr_host and fecr_props are compiled.
*/
module fecr_top_tb
  import fecr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ser_clk_i;
  logic ser_data_i;
  logic ser_en_i;
  logic rf_only_pin_i = 1'b0;
  logic servo_offset_scale_i = 1'b0;
  logic power_on_wr_i = 1'b0;
  logic power_on_wdata_i = 1'b0;
  logic cd_laser_en_i = 1'b1; // on early: standby must mask it
  logic dvd_laser_en_i = 1'b0;
  fecr_cd_t cd_cfg_o;
  fecr_rf_t rf_cfg_o;
  fecr_pd_t pd_cfg_o;
  logic [3:0] focus_servo_out_oe_o;
  logic [1:0] radial_servo_out_oe_o;
  logic rf_path_en_o;
  logic standby_o;
  logic cd_laser_supply_en_o;
  logic dvd_laser_supply_en_o;
  logic cd_laser_on_o;
  logic dvd_laser_on_o;
  logic offset_triple_o;
  logic [5:0] offset_c_mv_o;
  logic [5:0] offset_d_mv_o;
  logic [7:0] rf_corner_mhz_o;
  logic [7:0] leadlag_mhz_o;
  logic [7:0] lowpass_mhz_o;
  logic phase_code_rsvd_o;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0; // run length well under 8000 cycles
  logic [7:0] ll_exp [8] = '{8'h01, 8'h05, 8'h0A, 8'h12, 8'h18, 8'h00,
    8'h00, 8'h00};
  logic [7:0] lp_exp [8] = '{8'h0A, 8'h32, 8'h64, 8'hB4, 8'h00, 8'h00,
    8'h00, 8'hF0};

  fecr_top DUT (.*);
  fecr_host host (
    .core_clk_i(core_clk_i),
    .ser_clk_o(ser_clk_i),
    .ser_data_o(ser_data_i),
    .ser_en_o(ser_en_i)
  );

  always #20 core_clk_i = ~core_clk_i;

  // hang guard
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", what, exp, seen);
    end
  endtask

  // one whole word, then time for it to reach the outputs
  task automatic wr(input logic [3:0] sel, input logic [11:0] pl,
    input int half);
    host.send({sel, pl}, 16, half);
    repeat (12) @(negedge core_clk_i);
  endtask

  task automatic power(input logic v);
    power_on_wdata_i = v;
    power_on_wr_i = 1'b1;
    @(negedge core_clk_i);
    power_on_wr_i = 1'b0;
    repeat (3) @(negedge core_clk_i);
  endtask

  initial begin
    repeat (10) @(negedge core_clk_i);
    chk("rst", 16'({standby_o, cd_cfg_o}), 16'h0200);
    rst_n_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk("stby", 16'({focus_servo_out_oe_o, cd_laser_supply_en_o,
      cd_laser_on_o}), 16'h0000);
    power(1'b1);
    chk("run", 16'({standby_o, rf_path_en_o}), 16'h0001);
    chk("laser", 16'({cd_laser_on_o, dvd_laser_on_o, cd_laser_supply_en_o,
      dvd_laser_supply_en_o}), 16'h000A);
    cd_laser_en_i = 1'b0;
    dvd_laser_en_i = 1'b1;
    repeat (3) @(negedge core_clk_i);
    chk("laser", 16'({cd_laser_on_o, dvd_laser_on_o}), 16'h0001);
    wr(SEL_CD, 12'h7A5, 6);
    chk("cd", 16'(cd_cfg_o), 16'h00A5);
    chk("oe", 16'({focus_servo_out_oe_o, radial_servo_out_oe_o}),
      16'h003F);
    chk("mv", 16'({offset_triple_o, offset_c_mv_o, offset_d_mv_o}),
      16'h0346);
    servo_offset_scale_i = 1'b1;
    repeat (5) @(negedge core_clk_i);
    chk("mv3", 16'({offset_triple_o, offset_c_mv_o, offset_d_mv_o}),
      16'h1A14);
    wr(SEL_RF, 12'hFFF, 9);
    chk("rf", 16'(rf_cfg_o), 16'h03FF);
    chk("corner", 16'(rf_corner_mhz_o), 16'h0091);
    chk("cd kept", 16'(cd_cfg_o), 16'h00A5);
    wr(SEL_RF, 12'h100, 5);
    chk("rf", 16'(rf_cfg_o), 16'h0100);
    chk("corner", 16'(rf_corner_mhz_o), 16'h000C);
    // every phase code, unused bits set
    for (int i = 0; i < 8; i++) begin
      wr(SEL_PD, 12'hFC0 | 12'(i * 9), 6);
      chk("pd", 16'(pd_cfg_o), 16'(i * 9));
      chk("ll", 16'(leadlag_mhz_o), 16'(ll_exp[i]));
      chk("lp", 16'(lowpass_mhz_o), 16'(lp_exp[i]));
      chk("rsvd", 16'(phase_code_rsvd_o), 16'(i >= 4));
    end
    wr(SEL_CD, 12'h8A5, 6);
    chk("rf_only_mode", 16'({focus_servo_out_oe_o, radial_servo_out_oe_o,
      rf_path_en_o}), 16'h0001);
    // short frame and a foreign select are both ignored
    host.send(16'hD0A5, 15, 6);
    wr(4'hC, 12'h000, 6);
    chk("cd kept", 16'(cd_cfg_o), 16'h01A5);
    // a short frame taken as a word would land with select 1110
    chk("rf kept", 16'(rf_cfg_o), 16'h0100);
    chk("pd kept", 16'(pd_cfg_o), 16'h003F);
    wr(SEL_CD, 12'h0A5, 6);
    rf_only_pin_i = 1'b1;
    repeat (8) @(negedge core_clk_i);
    chk("pin", 16'({focus_servo_out_oe_o, radial_servo_out_oe_o}),
      16'h0000);
    rf_only_pin_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
    chk("pin", 16'({focus_servo_out_oe_o, radial_servo_out_oe_o}),
      16'h003F);
    power(1'b0);
    chk("off", 16'({standby_o, focus_servo_out_oe_o, radial_servo_out_oe_o,
      dvd_laser_supply_en_o, dvd_laser_on_o}), 16'h0100);
    end_of_test();
  end
endmodule

bind fecr_top fecr_props props_i (.*);
